// ===== design/isst_consts.vh
// constants of the slave status tracker: status word layout, codes, reset
// assumes inclusion by bare name from the design files of the tracker
`ifndef ISST_CONSTS_VH
`define ISST_CONSTS_VH

// register placement and reset
`define ISST_STATUS_ADDR 32'hffff092c
`define ISST_STATUS_RESET 16'h0000

// status word field positions
`define ISST_BIT_RESERVED 15
`define ISST_BIT_START_MATCH 14
`define ISST_BIT_REP_START 13
`define ISST_ID_MSB 12
`define ISST_ID_LSB 11
`define ISST_BIT_STOP_AFTER 10
`define ISST_GCT_MSB 9
`define ISST_GCT_LSB 8
`define ISST_BIT_GC_FLAG 7

// bytes recognised on the bus
`define ISST_BYTE_START 8'h01
`define ISST_BYTE_GC_ADDR 8'h00
`define ISST_BYTE_GC_RESET 8'h06
`define ISST_BYTE_GC_PROG 8'h04

// general call type codes
`define ISST_GCT_NONE 2'h0
`define ISST_GCT_RESET 2'h1
`define ISST_GCT_PROG 2'h2
`define ISST_GCT_HW 2'h3

// bit counter values inside a nine-bit slot
`define ISST_LAST_DATA_BIT 4'h7
`define ISST_ACK_BIT 4'h8

`endif

// ===== design/isst_bus_watch.v
// bus watcher: synchronises the pins, finds start, stop, clock edges, bytes
// assumes scl_in and sda_in come straight from pins, asynchronous to sys_clk
`timescale 1ns/1ps
`include "isst_consts.vh"

module isst_bus_watch (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // bus pins
    input wire scl_in,
    input wire sda_in,
    // events
    output wire start_det,
    output wire stop_det,
    output wire scl_fall,
    output reg byte_valid,
    output reg [7:0] byte_data
);

    reg scl_meta;
    reg sda_meta;
    reg scl_sync;
    reg sda_sync;
    reg scl_prev;
    reg sda_prev;
    reg [3:0] bit_cnt;
    reg [6:0] shift;
    wire scl_rise;

    // two-flop synchronisers, then one stage for edge finding
    always @(posedge sys_clk) begin
        if (rst) begin
            scl_meta <= 1'b1;
            sda_meta <= 1'b1;
            scl_sync <= 1'b1;
            sda_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            sda_meta <= sda_in;
            scl_sync <= scl_meta;
            sda_sync <= sda_meta;
            scl_prev <= scl_sync;
            sda_prev <= sda_sync;
        end
    end

    // data falling or rising while the clock stays high marks start and stop
    assign start_det = scl_sync & scl_prev & sda_prev & ~sda_sync;
    assign stop_det = scl_sync & scl_prev & ~sda_prev & sda_sync;
    assign scl_rise = scl_sync & ~scl_prev;
    assign scl_fall = ~scl_sync & scl_prev;

    // shift eight data bits, skip the ninth (acknowledge) bit
    always @(posedge sys_clk) begin
        if (rst) begin
            bit_cnt <= 4'h0;
            shift <= 7'h00;
            byte_valid <= 1'b0;
            byte_data <= 8'h00;
        end else begin
            byte_valid <= 1'b0;
            if (start_det || stop_det) begin
                bit_cnt <= 4'h0;
            end else if (scl_rise) begin
                if (bit_cnt == `ISST_ACK_BIT) begin
                    bit_cnt <= 4'h0;
                end else begin
                    shift <= {shift[5:0], sda_sync};
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == `ISST_LAST_DATA_BIT) begin
                        byte_valid <= 1'b1;
                        byte_data <= {shift, sda_sync};
                    end
                end
            end
        end
    end

endmodule // isst_bus_watch

// ===== design/isst_tracker.v
// slave status tracker: follows bus events and keeps the slave status word
// assumes control bits and identity registers come from logic on sys_clk,
// the pins are asynchronous, and the status word is read over the mmr port
`timescale 1ns/1ps
`include "isst_consts.vh"

module isst_tracker (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // two-wire bus pins, sda is open drain
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe_n,
    // slave control bits
    input wire slave_enable,
    input wire general_call_enable,
    input wire hw_general_call_enable,
    input wire stop_interrupt_enable,
    input wire general_call_clear,
    // slave identity registers, address in bits 7:1; the alternative one is compared as a whole byte
    input wire [7:0] slave_identity_reg0,
    input wire [7:0] slave_identity_reg1,
    input wire [7:0] slave_identity_reg2,
    input wire [7:0] slave_identity_reg3,
    input wire [7:0] alternative_identity_reg,
    // memory-mapped status read
    input wire [31:0] mmr_addr,
    input wire mmr_rd,
    output reg [15:0] mmr_rdata,
    // receive path and events
    output reg [7:0] rx_byte,
    output reg rx_push,
    output reg gc_reset_pulse,
    output wire stop_irq
);

    // frame states
    // idle: no frame open, or the last one ended with a stop
    // addr: a start was seen, the next byte is the address byte
    // gc: address 0x00 was taken, the next byte is the call command
    // data: a write to one of our identities, bytes go to the receive path
    // skip: the frame is not ours (or is a read), wait for stop or start
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_GC = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_SKIP = 3'd4;

    reg [2:0] state;
    reg start_match_flag;
    reg repeated_start_flag;
    reg [1:0] matched_identity_index;
    reg stop_after_start_flag;
    reg [1:0] general_call_type;
    reg general_call_flag;
    reg ack_pend;
    reg [15:0] status_word;
    reg addr_hit;
    reg [1:0] addr_idx;
    reg do_ack;
    wire start_det;
    wire stop_det;
    wire scl_fall;
    wire byte_valid;
    wire [7:0] byte_data;
    wire status_read;

    // pin synchronisation, condition and byte detection
    isst_bus_watch u_watch (
        .sys_clk(sys_clk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .start_det(start_det),
        .stop_det(stop_det),
        .scl_fall(scl_fall),
        .byte_valid(byte_valid),
        .byte_data(byte_data)
    );

    // compare a received address byte with one identity register
    function id_match;
        input [7:0] addr_byte;
        input [7:0] id_reg;
        begin
            id_match = (addr_byte[7:1] == id_reg[7:1]);
        end
    endfunction

    // lowest matching identity register wins when several hold one address
    // only bits 7:1 take part; bit 0 is the direction bit of the frame
    // the result is used only while the address byte is valid
    always @* begin
        addr_hit = 1'b1;
        addr_idx = 2'h0;
        if (id_match(byte_data, slave_identity_reg0)) begin
            addr_idx = 2'h0;
        end else if (id_match(byte_data, slave_identity_reg1)) begin
            addr_idx = 2'h1;
        end else if (id_match(byte_data, slave_identity_reg2)) begin
            addr_idx = 2'h2;
        end else if (id_match(byte_data, slave_identity_reg3)) begin
            addr_idx = 2'h3;
        end else begin
            addr_hit = 1'b0;
        end
    end

    // acknowledge decision for the byte just received
    always @* begin
        do_ack = 1'b0;
        case (state)
            ST_ADDR: begin
                if (byte_data == `ISST_BYTE_GC_ADDR) begin
                    do_ack = general_call_enable;
                end else if (byte_data != `ISST_BYTE_START) begin
                    do_ack = addr_hit;
                end
            end
            ST_GC: do_ack = 1'b1;
            ST_DATA: do_ack = 1'b1;
            default: do_ack = 1'b0;
        endcase
    end

    // a read of the status word at its own address
    // the strobe is one cycle wide; back to back reads each see the word
    // as it stood before their own edge
    assign status_read = mmr_rd && (mmr_addr == `ISST_STATUS_ADDR);

    // assemble the status word; the low status bits live elsewhere
    always @* begin
        status_word = `ISST_STATUS_RESET;
        status_word[`ISST_BIT_RESERVED] = 1'b0;
        status_word[`ISST_BIT_START_MATCH] = start_match_flag;
        status_word[`ISST_BIT_REP_START] = repeated_start_flag;
        status_word[`ISST_ID_MSB:`ISST_ID_LSB] = matched_identity_index;
        status_word[`ISST_BIT_STOP_AFTER] = stop_after_start_flag;
        status_word[`ISST_GCT_MSB:`ISST_GCT_LSB] = general_call_type;
        status_word[`ISST_BIT_GC_FLAG] = general_call_flag;
    end

    // registered read answer, unmapped addresses read zero
    always @(posedge sys_clk) begin
        if (rst) begin
            mmr_rdata <= 16'h0000;
        end else if (status_read) begin
            mmr_rdata <= status_word;
        end else begin
            mmr_rdata <= 16'h0000;
        end
    end

    // frame tracking and status flags; clears come first so sets win
    // priority of the bus events within one cycle:
    //   slave disabled  - frame dropped, flags kept for software
    //   stop            - closes the frame, may raise the stop flag
    //   start           - opens a frame, repeated if one was open
    //   byte            - advances the frame by its state
    // a read of the status word clears bits 13 and 10 in the same cycle
    // in which the old word is latched for the answer, so nothing set
    // between the read and the answer is lost: the set simply wins.
    // the call type field is set to the reset code by a call reset, only the clear
    // pulse from the control side removes it; a new call overwrites it.
    // the matched index survives a stop so software can look at it later
    always @(posedge sys_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            start_match_flag <= 1'b0;
            repeated_start_flag <= 1'b0;
            matched_identity_index <= 2'h0;
            stop_after_start_flag <= 1'b0;
            general_call_type <= `ISST_GCT_NONE;
            general_call_flag <= 1'b0;
            rx_byte <= 8'h00;
            rx_push <= 1'b0;
            gc_reset_pulse <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            gc_reset_pulse <= 1'b0;
            // software side effects
            if (status_read) begin
                repeated_start_flag <= 1'b0;
                stop_after_start_flag <= 1'b0;
            end
            if (general_call_clear) begin
                general_call_type <= `ISST_GCT_NONE;
                general_call_flag <= 1'b0;
            end
            // bus events
            if (!slave_enable) begin
                state <= ST_IDLE;
            end else if (stop_det) begin
                start_match_flag <= 1'b0;
                repeated_start_flag <= 1'b0;
                if (start_match_flag) begin
                    stop_after_start_flag <= 1'b1;
                end
                state <= ST_IDLE;
            end else if (start_det) begin
                if (state != ST_IDLE) begin
                    repeated_start_flag <= 1'b1;
                end
                state <= ST_ADDR;
            end else if (byte_valid) begin
                case (state)
                    ST_ADDR: begin
                        if (byte_data == `ISST_BYTE_START) begin
                            start_match_flag <= 1'b1;
                            state <= ST_SKIP;
                        end else if (byte_data == `ISST_BYTE_GC_ADDR) begin
                            if (general_call_enable) begin
                                start_match_flag <= 1'b1;
                                state <= ST_GC;
                            end else begin
                                state <= ST_SKIP;
                            end
                        end else if (addr_hit) begin
                            start_match_flag <= 1'b1;
                            matched_identity_index <= addr_idx;
                            // reads need the transmit side, not kept here
                            state <= byte_data[0] ? ST_SKIP : ST_DATA;
                        end else begin
                            state <= ST_SKIP;
                        end
                    end
                    ST_GC: begin
                        state <= ST_SKIP;
                        if (byte_data == `ISST_BYTE_GC_RESET) begin
                            // interface back to defaults, type set to the reset code
                            start_match_flag <= 1'b0;
                            repeated_start_flag <= 1'b0;
                            matched_identity_index <= 2'h0;
                            stop_after_start_flag <= 1'b0;
                            gc_reset_pulse <= 1'b1;
                            general_call_type <= `ISST_GCT_RESET;
                            general_call_flag <= 1'b1;
                        end else if (byte_data == `ISST_BYTE_GC_PROG) begin
                            general_call_type <= `ISST_GCT_PROG;
                            general_call_flag <= 1'b1;
                        end else if (hw_general_call_enable &&
                                     byte_data == alternative_identity_reg) begin
                            general_call_type <= `ISST_GCT_HW;
                            general_call_flag <= 1'b1;
                            rx_byte <= byte_data;
                            rx_push <= 1'b1;
                        end
                    end
                    ST_DATA: begin
                        rx_byte <= byte_data;
                        rx_push <= 1'b1;
                    end
                    default: state <= state;
                endcase
            end
        end
    end

    // acknowledge: pull sda low from the clock fall after a byte to the next
    // the pull starts about three cycles after the pin falls, well inside
    // the low phase, and ends the same way after the ninth clock falls,
    // so the master never sees data change while the clock is high.
    // start, stop or a disabled slave release the line at once, which
    // keeps a cut frame from leaving sda held low on the bus
    always @(posedge sys_clk) begin
        if (rst) begin
            ack_pend <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (!slave_enable || start_det || stop_det) begin
            ack_pend <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            if (byte_valid) begin
                ack_pend <= do_ack;
            end
            if (scl_fall) begin
                if (ack_pend) begin
                    sda_oe_n <= 1'b0;
                    ack_pend <= 1'b0;
                end else begin
                    sda_oe_n <= 1'b1;
                end
            end
        end
    end

    // open drain: only ever drives low
    // the pad drives sda_out while sda_oe_n is low and floats otherwise
    assign sda_out = 1'b0;

    // stop interrupt
    assign stop_irq = stop_after_start_flag & stop_interrupt_enable;

endmodule // isst_tracker

// ===== dv/isst_checker.sv
// checker: timing relations seen at the status tracker's ports
// assumes it is bound onto isst_tracker, single sys_clk domain
`timescale 1ns/1ps
`include "isst_consts.vh"

module isst_checker (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // bus pin and control
    input wire sda_in,
    input wire scl_in,
    input wire stop_interrupt_enable,
    input wire [31:0] mmr_addr,
    input wire mmr_rd,
    // results
    input wire [15:0] mmr_rdata,
    input wire rx_push,
    input wire gc_reset_pulse,
    input wire stop_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // status read with no sda edge nearby that could set a flag again
    sequence s_read;
        mmr_rd && mmr_addr == `ISST_STATUS_ADDR;
    endsequence
    sequence s_quiet_read;
        $stable(sda_in) [*6] ##0 s_read;
    endsequence

    a_irq_gated: assert property (
        !stop_interrupt_enable |-> !stop_irq) else $error("irq not gated");
    a_rdata_idle: assert property (
        !mmr_rd |=> mmr_rdata == 16'h0000) else $error("rdata not idle");
    a_unused_zero: assert property (
        mmr_rdata[15] == 1'b0 && mmr_rdata[6:0] == 7'h00)
        else $error("unused bits set");
    a_read_clears_stop: assert property (
        s_quiet_read |=> !stop_irq) else $error("read kept stop flag");
    a_reread_clears: assert property (
        s_quiet_read ##1 s_read |=> !mmr_rdata[13] && !mmr_rdata[10])
        else $error("read did not clear flags");
    a_reset_drops_irq: assert property (
        gc_reset_pulse |-> ##2 !stop_irq) else $error("call reset kept irq");
    a_stop_irq_source: assert property (
        $rose(stop_irq) && $stable(stop_interrupt_enable) |-> scl_in && sda_in)
        else $error("stop flag without stop");
    a_push_pulse: assert property (
        rx_push |=> !rx_push) else $error("push too long");
    a_gc_pulse_once: assert property (
        gc_reset_pulse |=> !gc_reset_pulse) else $error("reset pulse too long");
endmodule // isst_checker

bind isst_tracker isst_checker u_chk (.sys_clk(sys_clk), .rst(rst),
    .sda_in(sda_in), .scl_in(scl_in),
    .stop_interrupt_enable(stop_interrupt_enable), .mmr_addr(mmr_addr),
    .mmr_rd(mmr_rd), .mmr_rdata(mmr_rdata), .rx_push(rx_push),
    .gc_reset_pulse(gc_reset_pulse), .stop_irq(stop_irq));

// ===== dv/isst_bus_master.sv
// two-wire bus master model: drives scl, sda as open drain
// assumes a pull-up on sda and a 125 ns bus clock; scl idles high
`timescale 1ns/1ps

module isst_bus_master (
    // bus lines
    output reg scl,
    output reg sda_drv,
    input wire sda_line
);
    localparam real Q = 31.25;
    // lines released at time zero
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // start or repeated start: sda falls while scl is high
    task start_c;
        begin
            sda_drv = 1'b1;
            #Q scl = 1'b1;
            #Q sda_drv = 1'b0;
            #Q scl = 1'b0;
            #Q;
        end
    endtask
    // one bit held across the whole high phase
    task bit_c(input b);
        begin
            sda_drv = b;
            #Q scl = 1'b1;
            #(2 * Q) scl = 1'b0;
            #Q;
        end
    endtask
    // byte msb first, then ninth clock with sda released for the ack
    task byte_c(input [7:0] b, output ack);
        integer j;
        begin
            for (j = 7; j >= 0; j = j - 1) begin
                bit_c(b[j]);
            end
            sda_drv = 1'b1;
            #Q scl = 1'b1;
            #Q ack = !sda_line;
            #Q scl = 1'b0;
            #Q;
        end
    endtask
    // stop: sda rises while scl is high, bus left idle
    task stop_c;
        begin
            sda_drv = 1'b0;
            #Q scl = 1'b1;
            #Q sda_drv = 1'b1;
            #(2 * Q);
        end
    endtask
endmodule // isst_bus_master

// ===== dv/test_isst_tracker.sv
// testbench of the slave status tracker: bus frames, status reads
// assumes the bus master model and the bound checker are compiled first
`timescale 1ns/1ps
`include "isst_consts.vh"

module test_isst_tracker;
    // design signals
    reg sys_clk, rst, slave_en, gce, hwe, sie, gcc, mmr_rd;
    reg [7:0] id [0:3];
    reg [7:0] alt, data, code, last_rx;
    reg [31:0] mmr_addr;
    reg [1:0] e_idx, e_gct;
    reg [15:0] d;
    reg e_gc, ack;
    wire [15:0] mmr_rdata;
    wire [7:0] rx_byte;
    wire scl, sda_m, sda_out, sda_oe_n, rx_push, gc_pulse, stop_irq;
    wire sda = sda_m & (sda_oe_n | sda_out);
    integer err_total = 0, check_count = 0, gc_count = 0, i, k, base;

    isst_tracker dut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .slave_enable(slave_en), .general_call_enable(gce),
        .hw_general_call_enable(hwe), .stop_interrupt_enable(sie),
        .general_call_clear(gcc), .slave_identity_reg0(id[0]),
        .slave_identity_reg1(id[1]), .slave_identity_reg2(id[2]),
        .slave_identity_reg3(id[3]), .alternative_identity_reg(alt),
        .mmr_addr(mmr_addr), .mmr_rd(mmr_rd), .mmr_rdata(mmr_rdata),
        .rx_byte(rx_byte), .rx_push(rx_push), .gc_reset_pulse(gc_pulse),
        .stop_irq(stop_irq));
    isst_bus_master m (.scl(scl), .sda_drv(sda_m), .sda_line(sda));

    // 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // remember pushed bytes and count call resets
    always @(posedge sys_clk) begin
        if (rx_push) last_rx <= rx_byte;
        if (gc_pulse) gc_count <= gc_count + 1;
    end
    // expected status word from the bench's own state
    function [15:0] word(input st, input rep, input [1:0] ix, input sa);
        word = {1'b0, st, rep, ix, sa, e_gct, e_gc, 7'h00};
    endfunction
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    // n back-to-back reads, d holds the last answer
    task rd(input [31:0] a, input integer n);
        begin
            @(posedge sys_clk) mmr_rd <= 1'b1;
            mmr_addr <= a;
            repeat (n - 1) @(posedge sys_clk);
            @(posedge sys_clk) mmr_rd <= 1'b0;
            #1 d = mmr_rdata;
        end
    endtask
    task print_verdict;
        begin
            if (err_total == 0 && check_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        err_total = err_total + 1;
        print_verdict;
    end

    initial begin
        {rst, slave_en, gce, hwe, sie, gcc, mmr_rd} = 7'h40;
        mmr_addr = 32'h0;
        {e_idx, e_gct, e_gc, last_rx} = 13'h0;
        k = $urandom(31);
        k = $urandom % 16;
        base = $urandom % 4;
        for (i = 0; i < 4; i = i + 1) id[i] = 8'(32'h20 + 8 * k + 2 * i);
        alt = 8'($urandom) | 8'h81;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        slave_en <= 1'b1;
        hwe <= 1'b1;
        rd(`ISST_STATUS_ADDR, 1);
        chk(d, 16'h0000);
        rd(32'hffff0928, 1);
        chk(d, 16'h0000);
        // one write frame to each identity register, in turn from a random first one
        for (i = 0; i < 4; i = i + 1) begin
            k = (i + base) % 4;
            data = 8'($urandom);
            @(posedge sys_clk) sie <= i[0];
            m.start_c;
            m.byte_c(id[k], ack);
            chk({15'h0, ack}, 16'h0001);
            m.byte_c(data, ack);
            m.stop_c;
            e_idx = k[1:0];
            chk({15'h0, stop_irq}, {15'h0, i[0]});
            rd(`ISST_STATUS_ADDR, 1);
            chk(d, word(1'b0, 1'b0, e_idx, 1'b1));
            rd(`ISST_STATUS_ADDR, 2);
            chk(d, word(1'b0, 1'b0, e_idx, 1'b0));
        end
        // repeated start switching identity
        m.start_c;
        m.byte_c(id[2], ack);
        m.byte_c(data, ack);
        m.start_c;
        m.byte_c(id[1], ack);
        rd(`ISST_STATUS_ADDR, 1);
        chk(d, word(1'b1, 1'b1, 2'h1, 1'b0));
        rd(`ISST_STATUS_ADDR, 1);
        chk(d, word(1'b1, 1'b0, 2'h1, 1'b0));
        m.stop_c;
        e_idx = 2'h1;
        rd(`ISST_STATUS_ADDR, 1);
        chk(d, word(1'b0, 1'b0, e_idx, 1'b1));
        // start byte
        m.start_c;
        m.byte_c(8'h01, ack);
        chk({15'h0, ack}, 16'h0000);
        rd(`ISST_STATUS_ADDR, 1);
        chk(d, word(1'b1, 1'b0, e_idx, 1'b0));
        m.stop_c;
        rd(`ISST_STATUS_ADDR, 2);
        chk(d, word(1'b0, 1'b0, e_idx, 1'b0));
        // general calls: disabled, alternative id, program, reset
        for (i = 0; i < 4; i = i + 1) begin
            code = (i == 1) ? alt : (i == 2) ? 8'h04 : 8'h06;
            @(posedge sys_clk) gce <= (i != 0);
            m.start_c;
            m.byte_c(8'h00, ack);
            rd(`ISST_STATUS_ADDR, 1);
            chk(d, word(i != 0, 1'b0, e_idx, 1'b0));
            m.byte_c(code, ack);
            m.stop_c;
            if (i != 0) begin
                e_gc = 1'b1;
                e_gct = (i == 1) ? 2'h3 : (i == 2) ? 2'h2 : 2'h1;
            end
            if (i == 3) e_idx = 2'h0;
            rd(`ISST_STATUS_ADDR, 1);
            chk(d, word(1'b0, 1'b0, e_idx, i == 1 || i == 2));
            if (i == 1) chk({8'h0, last_rx}, {8'h0, alt});
            @(posedge sys_clk) gcc <= 1'b1;
            @(posedge sys_clk) gcc <= 1'b0;
            {e_gct, e_gc} = 3'h0;
            rd(`ISST_STATUS_ADDR, 1);
            chk(d, word(1'b0, 1'b0, e_idx, 1'b0));
        end
        chk(gc_count[15:0], 16'h0001);
        // a disabled slave neither acknowledges nor records a frame
        @(posedge sys_clk) slave_en <= 1'b0;
        m.start_c;
        m.byte_c(id[0], ack);
        m.stop_c;
        chk({15'h0, ack}, 16'h0000);
        rd(`ISST_STATUS_ADDR, 1);
        chk(d, word(1'b0, 1'b0, e_idx, 1'b0));
        // leave a stop flag set, then reset in mid-run
        @(posedge sys_clk) slave_en <= 1'b1;
        sie <= 1'b1;
        m.start_c;
        m.byte_c(id[3], ack);
        m.stop_c;
        chk({15'h0, stop_irq}, 16'h0001);
        @(posedge sys_clk) rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        chk({15'h0, stop_irq}, 16'h0000);
        rd(`ISST_STATUS_ADDR, 1);
        chk(d, 16'h0000);
        print_verdict;
    end
endmodule // test_isst_tracker
